// *** src/tcc_pkg.sv ***
package tcc_pkg;
	localparam int ADDR_W = 10;
	localparam int IDX_W = 8;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL_A = 8'h2f;
	localparam logic [7:0] IDX_CTRL_B = 8'h2e;
	localparam logic [7:0] IDX_COUNT = 8'h2c;
	localparam logic [7:0] IDX_CMP_A = 8'h2a;
	localparam logic [7:0] IDX_CMP_B = 8'h28;
	localparam logic [7:0] IDX_CAPT = 8'h24;
	localparam logic [7:0] IDX_AUX = 8'h30;
	// control a fields
	localparam int CA_OUTA_LSB = 6;
	localparam int CA_OUTB_LSB = 4;
	localparam int CA_PWM_LSB = 0;
	// control b fields
	localparam int CB_NOISE = 7;
	localparam int CB_EDGE = 6;
	localparam int CB_CTC = 3;
	localparam int CB_CLK_LSB = 0;
	// aux fields
	localparam int AUX_CMP_SRC = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [2:0] CS_STOP = 3'b000;
	localparam logic [2:0] CS_CLK = 3'b001;
	localparam logic [2:0] CS_DIV8 = 3'b010;
	localparam logic [2:0] CS_DIV64 = 3'b011;
	localparam logic [2:0] CS_DIV256 = 3'b100;
	localparam logic [2:0] CS_DIV1024 = 3'b101;
	localparam logic [2:0] CS_EXT_FALL = 3'b110;
	localparam logic [2:0] CS_EXT_RISE = 3'b111;
	localparam logic [9:0] PRE_M8 = 10'h007;
	localparam logic [9:0] PRE_M64 = 10'h03f;
	localparam logic [9:0] PRE_M256 = 10'h0ff;
	localparam logic [9:0] PRE_M1024 = 10'h3ff;
	localparam logic [1:0] OM_OFF = 2'b00;
	localparam logic [1:0] OM_TOGGLE = 2'b01;
	localparam logic [1:0] OM_LOW = 2'b10;
	localparam logic [1:0] OM_HIGH = 2'b11;
	localparam logic [1:0] PWM_OFF = 2'b00;
	localparam logic [1:0] PWM_8 = 2'b01;
	localparam logic [1:0] PWM_9 = 2'b10;
	localparam logic [15:0] TOP_8 = 16'h00ff;
	localparam logic [15:0] TOP_9 = 16'h01ff;
	localparam logic [15:0] TOP_10 = 16'h03ff;
	localparam int NOISE_SAMPLES = 4;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tcc_pkg

// *** src/tcc_cap_if.sv ***
`timescale 1ns/100ps
interface tcc_cap_if;
	logic noise_en;
	logic edge_rise;
	logic use_cmp;
	logic event_p;
	modport ctrl (output noise_en, output edge_rise, output use_cmp,
		input event_p);
	modport filt (input noise_en, input edge_rise, input use_cmp,
		output event_p);
endinterface : tcc_cap_if

// *** src/tcc_capture.sv ***
`timescale 1ns/100ps
module tcc_capture
	import tcc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic capture_input_pin,
	input wire logic analog_cmp_out,
	tcc_cap_if.filt cap
);
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic cmp_s1_reg;
	logic cmp_s2_reg;
	logic [NOISE_SAMPLES-1:0] samp_reg;
	logic level_reg;
	logic event_reg;
	wire logic src;
	wire logic all_hi;
	wire logic all_lo;
	wire logic level_next;
	wire logic rise;
	wire logic fall;

	// sampled every aclk, which is the crystal rate here
	assign src = cap.use_cmp ? cmp_s2_reg : pin_s2_reg;
	assign all_hi = &samp_reg;
	assign all_lo = ~|samp_reg;
	// with the noise filter on, filtered level only moves once four samples agree
	assign level_next = cap.noise_en ?
		(all_hi ? 1'b1 : (all_lo ? 1'b0 : level_reg)) : samp_reg[0];
	assign rise = level_next & ~level_reg;
	assign fall = ~level_next & level_reg;
	assign cap.event_p = event_reg;

	always_ff @(posedge aclk)
	begin
		pin_s1_reg <= capture_input_pin;
		pin_s2_reg <= pin_s1_reg;
		cmp_s1_reg <= analog_cmp_out;
		cmp_s2_reg <= cmp_s1_reg;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			samp_reg <= '0;
			level_reg <= 1'b0;
			event_reg <= 1'b0;
		end
		else
		begin
			samp_reg <= {samp_reg[NOISE_SAMPLES-2:0], src};
			level_reg <= level_next;
			event_reg <= cap.edge_rise ? rise : fall;
		end
	end
endmodule : tcc_capture

// *** src/tcc_top.sv ***
// Operation
// - counter runs on system, prescaled or external clock, or stops
// - external clock is synchronised and sampled on each rising aclk edge
// - two independent channels compare their value against the counter
// - optional counter clear on channel a match
// - outside pwm, mode 00 off, 01 toggle, 10 low, 11 high
// - in pwm mode output mode fields take their pwm meaning
// - pwm select 00 off, 01 8-bit, 10 9-bit, 11 10-bit
// - pwm yields two glitch-free centred pulse outputs
// - qualified capture event copies counter into capture register
// - analog comparator output may be chosen as capture trigger
// - noise filter needs four agreeing samples, else first edge fires
// - capture input sampled at crystal clock rate
// - edge select: cleared falling, set rising
// - unused control bits read zero and ignore writes
// - clock select codes stop, clk, /8, /64, /256, /1024, ext fall, rise
// - clear on match zeroes counter the cycle after match; not in pwm
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module tcc_top
	import tcc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tcc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tcc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_clock_pin,
	input wire logic capture_input_pin,
	input wire logic analog_cmp_out,
	output logic compare_out_a_pin,
	output logic compare_out_a_oe,
	output logic compare_out_b_pin,
	output logic compare_out_b_oe
);
	tcc_cap_if cap_bus ();

	logic [1:0] outmode_a_reg;
	logic [1:0] outmode_b_reg;
	logic [1:0] pwm_sel_reg;
	logic noise_en_reg;
	logic edge_sel_reg;
	logic ctc_reg;
	logic [2:0] clk_sel_reg;
	logic cmp_src_reg;
	logic [15:0] count_reg;
	logic [15:0] cmp_a_reg;
	logic [15:0] cmp_b_reg;
	logic [15:0] capt_reg;
	logic [15:0] buf_a_reg;
	logic [15:0] buf_b_reg;
	logic dir_down_reg;
	logic [9:0] pre_reg;
	logic ext_s1_reg;
	logic ext_s2_reg;
	logic ext_s3_reg;
	logic match_a_reg;
	logic match_b_reg;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [tcc_pkg::ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;

	function automatic logic [IDX_W-1:0] idx_of(
		input logic [ADDR_W-1:0] a);
		idx_of = a[ADDR_W-1:2];
	endfunction : idx_of

	function automatic logic mapped(input logic [IDX_W-1:0] i);
		mapped = (i == IDX_CTRL_A) || (i == IDX_CTRL_B) ||
			(i == IDX_COUNT) || (i == IDX_CMP_A) ||
			(i == IDX_CMP_B) || (i == IDX_CAPT) || (i == IDX_AUX);
	endfunction : mapped

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic pre_hit(input logic [9:0] p,
		input logic [9:0] m);
		pre_hit = (p & m) == m;
	endfunction : pre_hit

	// bus handshakes
	wire logic aw_take = s_axi_awvalid & s_axi_awready;
	wire logic w_take = s_axi_wvalid & s_axi_wready;
	wire logic ar_take = s_axi_arvalid & s_axi_arready;
	wire logic aw_have = aw_hold_reg | aw_take;
	wire logic w_have = w_hold_reg | w_take;
	wire logic do_write = aw_have & w_have;
	wire logic [ADDR_W-1:0] wa = aw_take ? s_axi_awaddr : awaddr_reg;
	wire logic [31:0] wd = w_take ? s_axi_wdata : wdata_reg;
	wire logic [3:0] ws = w_take ? s_axi_wstrb : wstrb_reg;
	wire logic [IDX_W-1:0] widx = idx_of(wa);
	wire logic [IDX_W-1:0] ridx = idx_of(s_axi_araddr);
	wire logic aw_hold_next = aw_have & ~do_write;
	wire logic w_hold_next = w_have & ~do_write;
	wire logic bvalid_next = do_write | (s_axi_bvalid & ~s_axi_bready);
	wire logic rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
	wire logic wr_lo = do_write & ws[0];
	wire logic wr_ctrl_a = wr_lo & (widx == IDX_CTRL_A);
	wire logic wr_ctrl_b = wr_lo & (widx == IDX_CTRL_B);
	wire logic wr_aux = wr_lo & (widx == IDX_AUX);
	wire logic wr_count = do_write & (widx == IDX_COUNT);
	wire logic wr_cmp_a = do_write & (widx == IDX_CMP_A);
	wire logic wr_cmp_b = do_write & (widx == IDX_CMP_B);

	// reserved bits are not stored, so they read back as zero
	wire logic [7:0] ctrl_a_rd = {outmode_a_reg, outmode_b_reg, 2'b00,
		pwm_sel_reg};
	wire logic [7:0] ctrl_b_rd = {noise_en_reg, edge_sel_reg, 2'b00,
		ctc_reg, clk_sel_reg};
	wire logic [31:0] rd_mux =
		(ridx == IDX_CTRL_A) ? {24'h00_0000, ctrl_a_rd} :
		(ridx == IDX_CTRL_B) ? {24'h00_0000, ctrl_b_rd} :
		(ridx == IDX_COUNT) ? {16'h0000, count_reg} :
		(ridx == IDX_CMP_A) ? {16'h0000, cmp_a_reg} :
		(ridx == IDX_CMP_B) ? {16'h0000, cmp_b_reg} :
		(ridx == IDX_CAPT) ? {16'h0000, capt_reg} :
		(ridx == IDX_AUX) ? {31'h0000_0000, cmp_src_reg} : 32'h0000_0000;

	// clock source; external edges come off the synchroniser output
	wire logic ext_rise = ext_s2_reg & ~ext_s3_reg;
	wire logic ext_fall = ~ext_s2_reg & ext_s3_reg;
	wire logic tick =
		(clk_sel_reg == CS_CLK) ? 1'b1 :
		(clk_sel_reg == CS_DIV8) ? pre_hit(pre_reg, PRE_M8) :
		(clk_sel_reg == CS_DIV64) ? pre_hit(pre_reg, PRE_M64) :
		(clk_sel_reg == CS_DIV256) ? pre_hit(pre_reg, PRE_M256) :
		(clk_sel_reg == CS_DIV1024) ? pre_hit(pre_reg, PRE_M1024) :
		(clk_sel_reg == CS_EXT_FALL) ? ext_fall :
		(clk_sel_reg == CS_EXT_RISE) ? ext_rise : 1'b0;

	// pwm resolution and up/down turn points
	wire logic pwm_on = pwm_sel_reg != PWM_OFF;
	wire logic [15:0] pwm_top = (pwm_sel_reg == PWM_8) ? TOP_8 :
		(pwm_sel_reg == PWM_9) ? TOP_9 : TOP_10;
	wire logic at_top = count_reg >= pwm_top;
	wire logic at_bottom = count_reg == WORD_RESET;
	wire logic go_down = dir_down_reg ? ~at_bottom : at_top;
	wire logic [15:0] cnt_up = count_reg + 16'h0001;
	wire logic [15:0] cnt_dn = count_reg - 16'h0001;
	wire logic [15:0] cnt_adv = (pwm_on & go_down) ? cnt_dn : cnt_up;

	// match reg is one cycle late, so the clear lands the cycle after
	wire logic clear_now = match_a_reg & ctc_reg & ~pwm_on;
	wire logic advance = tick & ~wr_count & ~clear_now;
	// a software write onto the compare value does not count
	wire logic hit_a = advance & ~pwm_on & (cnt_adv == cmp_a_reg);
	wire logic hit_b = advance & ~pwm_on & (cnt_adv == cmp_b_reg);
	// compare values are taken only at the turn, so no glitches
	wire logic buf_load = ~pwm_on | (tick & at_top & ~dir_down_reg);
	wire logic pwm_lvl_a = cnt_adv < buf_a_reg;
	wire logic pwm_lvl_b = cnt_adv < buf_b_reg;

	assign cap_bus.noise_en = noise_en_reg;
	assign cap_bus.edge_rise = edge_sel_reg;
	assign cap_bus.use_cmp = cmp_src_reg;

	tcc_capture u_capture (
		.aclk(aclk),
		.aresetn(aresetn),
		.capture_input_pin(capture_input_pin),
		.analog_cmp_out(analog_cmp_out),
		.cap(cap_bus.filt)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
		end
		else
		begin
			s_axi_awready <= ~aw_hold_next & ~bvalid_next;
			s_axi_wready <= ~w_hold_next & ~bvalid_next;
			s_axi_bvalid <= bvalid_next;
			s_axi_arready <= ~rvalid_next;
			s_axi_rvalid <= rvalid_next;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end
		else
		begin
			if (aw_take)
				awaddr_reg <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write)
				s_axi_bresp <= mapped(widx) ? RESP_OKAY : RESP_SLVERR;
			if (ar_take)
			begin
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			outmode_a_reg <= CTRL_RESET[CA_OUTA_LSB +: 2];
			outmode_b_reg <= CTRL_RESET[CA_OUTB_LSB +: 2];
			pwm_sel_reg <= CTRL_RESET[CA_PWM_LSB +: 2];
			noise_en_reg <= CTRL_RESET[CB_NOISE];
			edge_sel_reg <= CTRL_RESET[CB_EDGE];
			ctc_reg <= CTRL_RESET[CB_CTC];
			clk_sel_reg <= CTRL_RESET[CB_CLK_LSB +: 3];
			cmp_src_reg <= CTRL_RESET[AUX_CMP_SRC];
		end
		else
		begin
			if (wr_ctrl_a)
			begin
				outmode_a_reg <= wd[CA_OUTA_LSB +: 2];
				outmode_b_reg <= wd[CA_OUTB_LSB +: 2];
				pwm_sel_reg <= wd[CA_PWM_LSB +: 2];
			end
			if (wr_ctrl_b)
			begin
				noise_en_reg <= wd[CB_NOISE];
				edge_sel_reg <= wd[CB_EDGE];
				ctc_reg <= wd[CB_CTC];
				clk_sel_reg <= wd[CB_CLK_LSB +: 3];
			end
			if (wr_aux)
				cmp_src_reg <= wd[AUX_CMP_SRC];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmp_a_reg <= WORD_RESET;
			cmp_b_reg <= WORD_RESET;
			buf_a_reg <= WORD_RESET;
			buf_b_reg <= WORD_RESET;
		end
		else
		begin
			if (wr_cmp_a)
				cmp_a_reg <= merge16(cmp_a_reg, wd, ws);
			if (wr_cmp_b)
				cmp_b_reg <= merge16(cmp_b_reg, wd, ws);
			if (buf_load)
			begin
				buf_a_reg <= cmp_a_reg;
				buf_b_reg <= cmp_b_reg;
			end
		end
	end

	// prescaler runs free, shared by all divided rates
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pre_reg <= 10'h000;
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end
		else
		begin
			pre_reg <= pre_reg + 10'h001;
			ext_s1_reg <= ext_clock_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_reg <= WORD_RESET;
			dir_down_reg <= 1'b0;
		end
		else if (wr_count)
			count_reg <= merge16(count_reg, wd, ws);
		else if (clear_now)
			count_reg <= WORD_RESET;
		else if (tick)
		begin
			count_reg <= cnt_adv;
			dir_down_reg <= pwm_on & go_down;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			match_a_reg <= 1'b0;
			match_b_reg <= 1'b0;
			capt_reg <= WORD_RESET;
		end
		else
		begin
			match_a_reg <= hit_a;
			match_b_reg <= hit_b;
			if (cap_bus.event_p)
				capt_reg <= count_reg;
		end
	end

	// pin drivers; enable follows the mode, read in its pwm meaning while pwm is on, so mode and pwm select set the direction
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			compare_out_a_pin <= 1'b0;
			compare_out_b_pin <= 1'b0;
			compare_out_a_oe <= 1'b0;
			compare_out_b_oe <= 1'b0;
		end
		else
		begin
			compare_out_a_oe <= pwm_on ? outmode_a_reg[1] :
				(outmode_a_reg != OM_OFF);
			compare_out_b_oe <= pwm_on ? outmode_b_reg[1] :
				(outmode_b_reg != OM_OFF);
			if (pwm_on & advance)
			begin
				// 10 non-inverted, 11 inverted centred pulse
				compare_out_a_pin <= pwm_lvl_a ^ outmode_a_reg[0];
				compare_out_b_pin <= pwm_lvl_b ^ outmode_b_reg[0];
			end
			else if (!pwm_on)
			begin
				if (match_a_reg)
				begin
					unique case (outmode_a_reg)
						OM_TOGGLE: compare_out_a_pin <= ~compare_out_a_pin;
						OM_LOW: compare_out_a_pin <= 1'b0;
						OM_HIGH: compare_out_a_pin <= 1'b1;
						OM_OFF: compare_out_a_pin <= compare_out_a_pin;
					endcase
				end
				if (match_b_reg)
				begin
					unique case (outmode_b_reg)
						OM_TOGGLE: compare_out_b_pin <= ~compare_out_b_pin;
						OM_LOW: compare_out_b_pin <= 1'b0;
						OM_HIGH: compare_out_b_pin <= 1'b1;
						OM_OFF: compare_out_b_pin <= compare_out_b_pin;
					endcase
				end
			end
		end
	end
endmodule : tcc_top

// *** tb/tcc_assertions.sv ***
`timescale 1ns/100ps
module tcc_assertions
	import tcc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic compare_out_a_pin,
	input wire logic compare_out_a_oe,
	input wire logic compare_out_b_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence aw_w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (aw_w_taken |=> s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_busy_no_ready: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write slot offered while answer pending");
	a_upper_zero: assert property (s_axi_rvalid |->
		s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_err_reads_zero: assert property (s_axi_rvalid &&
		s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
		else $error("error read returned data");
	// a level may only move while the timer owns the pin
	a_pin_a_driven: assert property ($changed(compare_out_a_pin) |->
		compare_out_a_oe || $past(compare_out_a_oe))
		else $error("pin a moved while released");
	a_reset_quiet: assert property ($rose(aresetn) |->
		!compare_out_a_oe && !compare_out_b_oe)
		else $error("pins driven after reset");
endmodule : tcc_assertions

bind tcc_top tcc_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.compare_out_a_pin, .compare_out_a_oe, .compare_out_b_oe);

// *** tb/tcc_pins_model.sv ***
`timescale 1ns/100ps
module tcc_pins_model
(
	input wire logic aclk,
	output logic ext_clock_pin = 1'b0,
	output logic capture_input_pin = 1'b0,
	output logic analog_cmp_out = 1'b0
);
	// three cycles per level, well above the one-cycle minimum
	task automatic ext_pulses(input int n);
		repeat (n)
		begin
			repeat (3) @(posedge aclk);
			ext_clock_pin <= 1'b1;
			repeat (3) @(posedge aclk);
			ext_clock_pin <= 1'b0;
		end
	endtask : ext_pulses
	task automatic cap_level(input logic v, input logic cmp, input int n);
		if (cmp)
			analog_cmp_out <= v;
		else
			capture_input_pin <= v;
		repeat (n) @(posedge aclk);
	endtask : cap_level
endmodule : tcc_pins_model

// *** tb/test_tcc_top.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
	err_total++; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_tcc_top
	import tcc_pkg::*;
;
	localparam logic [9:0] A_CA = {IDX_CTRL_A, 2'b00};
	localparam logic [9:0] A_CB = {IDX_CTRL_B, 2'b00};
	localparam logic [9:0] A_CNT = {IDX_COUNT, 2'b00};
	localparam logic [9:0] A_CMA = {IDX_CMP_A, 2'b00};
	localparam logic [9:0] A_CMB = {IDX_CMP_B, 2'b00};
	localparam logic [9:0] A_CAP = {IDX_CAPT, 2'b00};
	localparam logic [9:0] A_AUX = {IDX_AUX, 2'b00};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rdv;
	logic ext_clock_pin, capture_input_pin, analog_cmp_out;
	logic compare_out_a_pin, compare_out_a_oe;
	logic compare_out_b_pin, compare_out_b_oe;
	int err_total = 0;
	int total_checks = 0;
	tcc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ext_clock_pin, .capture_input_pin,
		.analog_cmp_out, .compare_out_a_pin, .compare_out_a_oe,
		.compare_out_b_pin, .compare_out_b_oe);
	tcc_pins_model u_pins (.aclk, .ext_clock_pin, .capture_input_pin,
		.analog_cmp_out);
	always #5 aclk = ~aclk;
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			ad = ad | s_axi_awready;
			wd = wd | s_axi_wready;
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		rdv = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic t_regs;
		rd(A_CA);
		`CHK("ctrl_a reset", 32'h0000_0000, rdv)
		wr(A_CA, 32'h0000_00ff);
		rd(A_CA);
		`CHK("ctrl_a reserved", 32'h0000_00f3, rdv)
		wr(A_CB, 32'h0000_0030);
		rd(A_CB);
		`CHK("ctrl_b reserved", 32'h0000_0000, rdv)
		wr(A_CA, 32'h0000_0000);
		rd(10'h3fc);
		`CHK("unmapped resp", RESP_SLVERR, resp)
		wr(A_CAP, 32'h0000_1111);
		`CHK("capture write resp", RESP_OKAY, resp)
		rd(A_CAP);
		`CHK("capture read only", 32'h0000_0000, rdv)
	endtask : t_regs
	task automatic t_compare;
		int n;
		logic p;
		wr(A_CMA, 32'h0000_0020);
		wr(A_CMB, 32'h0000_0010);
		wr(A_CNT, 32'h0000_0000);
		// drive enabled by the mode before any match is expected
		wr(A_CA, 32'h0000_00f0);
		wr(A_CB, 32'h0000_0009);
		repeat (40) @(posedge aclk);
		`CHK("pin a set", 2'h3, {compare_out_a_pin, compare_out_a_oe})
		`CHK("pin b set", 2'h3, {compare_out_b_pin, compare_out_b_oe})
		// no compare interrupt in this block, so nothing to mask first
		wr(A_CA, 32'h0000_00a0);
		repeat (40) @(posedge aclk);
		`CHK("pins low", 2'h0, {compare_out_a_pin, compare_out_b_pin})
		rd(A_CNT);
		`CHK("count capped", 1'b1, rdv <= 32'h0000_0020)
		wr(A_CA, 32'h0000_0040);
		n = 0;
		p = compare_out_a_pin;
		repeat (330)
		begin
			@(posedge aclk);
			if (compare_out_a_pin !== p) n++;
			p = compare_out_a_pin;
		end
		`CHK("toggles", 1'b1, n >= 9 && n <= 11)
		wr(A_CB, 32'h0000_0001);
		repeat (60) @(posedge aclk);
		rd(A_CNT);
		`CHK("no clear", 1'b1, rdv > 32'h0000_0020)
		wr(A_CA, 32'h0000_0000);
	endtask : t_compare
	task automatic t_clocks;
		int div [4] = '{8, 64, 256, 1024};
		for (int i = 0; i < 4; i++)
		begin
			wr(A_CB, 32'(CS_DIV8 + 3'(i)));
			wr(A_CNT, 32'h0000_0000);
			repeat (4 * div[i]) @(posedge aclk);
			rd(A_CNT);
			`CHK("prescaled", 1'b1, rdv >= 3 && rdv <= 5)
		end
		wr(A_CB, 32'h0000_0000);
		wr(A_CNT, 32'h0000_0055);
		repeat (50) @(posedge aclk);
		rd(A_CNT);
		`CHK("stopped", 32'h0000_0055, rdv)
		for (int e = 0; e < 2; e++)
		begin
			wr(A_CB, 32'(CS_EXT_FALL + 3'(e)));
			wr(A_CNT, 32'h0000_0000);
			u_pins.ext_pulses(6);
			repeat (10) @(posedge aclk);
			rd(A_CNT);
			`CHK("ext count", 32'h0000_0006, rdv)
		end
	endtask : t_clocks
	// counter held still so each captured value names its own event
	task automatic t_capture;
		wr(A_CB, 32'h0000_0040);
		wr(A_CNT, 32'h0000_1234);
		u_pins.cap_level(1'b1, 1'b0, 10);
		rd(A_CAP);
		`CHK("capture rise", 32'h0000_1234, rdv)
		wr(A_CNT, 32'h0000_5555);
		u_pins.cap_level(1'b0, 1'b0, 10);
		wr(A_CB, 32'h0000_0000);
		u_pins.cap_level(1'b1, 1'b0, 10);
		rd(A_CAP);
		`CHK("edges ignored", 32'h0000_1234, rdv)
		u_pins.cap_level(1'b0, 1'b0, 10);
		rd(A_CAP);
		`CHK("capture fall", 32'h0000_5555, rdv)
		wr(A_CB, 32'h0000_00c0);
		wr(A_CNT, 32'h0000_0777);
		u_pins.cap_level(1'b1, 1'b0, 2);
		u_pins.cap_level(1'b0, 1'b0, 10);
		rd(A_CAP);
		`CHK("glitch dropped", 32'h0000_5555, rdv)
		u_pins.cap_level(1'b1, 1'b0, 12);
		rd(A_CAP);
		`CHK("filtered capture", 32'h0000_0777, rdv)
		wr(A_AUX, 32'h0000_0001);
		wr(A_CB, 32'h0000_0040);
		wr(A_CNT, 32'h0000_0abc);
		u_pins.cap_level(1'b1, 1'b1, 10);
		rd(A_CAP);
		`CHK("comparator capture", 32'h0000_0abc, rdv)
	endtask : t_capture
	task automatic t_pwm;
		int n;
		wr(A_CMA, 32'h0000_0080);
		wr(A_CNT, 32'h0000_0000);
		wr(A_CA, 32'h0000_0081);
		wr(A_CB, 32'h0000_0001);
		repeat (520) @(posedge aclk);
		n = 0;
		repeat (1020)
		begin
			@(posedge aclk);
			n += int'(compare_out_a_pin);
		end
		`CHK("pwm high time", 1'b1, n > 490 && n < 530)
		`CHK("pwm drives", 1'b1, compare_out_a_oe)
		// 9-bit inverted: high while count >= 0x80, 767 of 1022 cycles
		wr(A_CA, 32'h0000_00c2);
		repeat (1100) @(posedge aclk);
		n = 0;
		repeat (1022)
		begin
			@(posedge aclk);
			n += int'(compare_out_a_pin);
		end
		`CHK("pwm9 inverted", 1'b1, n > 750 && n < 785)
		`CHK("pwm oe", 2'h2, {compare_out_a_oe, compare_out_b_oe})
	endtask : t_pwm
	// reset in mid-run, with pwm driving pin a
	task automatic t_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		`CHK("oe in reset", 2'h0, {compare_out_a_oe, compare_out_b_oe})
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(A_CA);
		`CHK("ctrl_a after reset", 32'h0000_0000, rdv)
		rd(A_CNT);
		`CHK("count after reset", 32'h0000_0000, rdv)
		rd(A_CAP);
		`CHK("capture after reset", 32'h0000_0000, rdv)
	endtask : t_reset
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_regs();
		t_compare();
		t_clocks();
		t_capture();
		t_pwm();
		t_reset();
		complete_run();
	end
	initial
	begin
		repeat (60000) @(posedge aclk);
		err_total++;
		complete_run();
	end
endmodule : test_tcc_top
